// *** hw/brs_top.sv ***
// Board reset sequencer, setup switches, indicators and back I/O lines
//
// Behaviour
// (R1) Button held over two seconds gives a cold reset: reload logic, hard CPU reset.
// (R2) Button held under two seconds gives a warm reset: logic reset, CPU soft exception.
// (R3) Remote opto input: over two seconds cold, shorter pulse warm.
// (R4) Backplane reset is cold when backplane_reset_kind set, warm otherwise (default).
// (R5) Boot source setting on selects serial flash, off selects parallel flash.
// (R6) Logic-loaded indicator lit only when all logic configured; dark during reload.
// (R7) User indicator follows bit 7 of local_ctrl_reg6.
// (R8) Hot-swap indicator lit only in the safe-to-remove protocol state.
// (R9) System-slot indicator lit when board is system slot.
// (R10) Over-current indicator follows fault report; supply-ok lit only when supplies good.
// (R11) Two differential back lines fully software driven via local_ctrl_reg0.
// (R12) Trigger line is timer-driven output or interrupt-raising input.
// (R13) Spread-clock setting selects 100 MHz spread clock offset by geographic address.
// (R14) ext_bus_clock_mode on drives dual clock, off single clock.
// (R15) short_scan_chain_sel on routes short chain, off full boundary-scan chain.
// (R16) cpu_probe_sel on connects CPU scan port to external probe, else boundary scan.
// (R17) mezz_scan_bypass on ties test data in to out at first mezzanine slot.
// (R18) Reset inputs synchronised, debounced, timed in clocks, classified on release; the backplane reset is taken unsynchronised on its rising edge.
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module brs_top #(
	parameter int unsigned HOLD_CYC  = brs_pkg::HOLD_LIMIT_CYC,
	parameter int unsigned DEB_CYC   = brs_pkg::DEBOUNCE_CYC,
	parameter int unsigned COLD_CYC  = brs_pkg::COLD_PULSE_CYC,
	parameter int unsigned WARM_CYC  = brs_pkg::WARM_PULSE_CYC,
	parameter int unsigned GA_W      = 5
) (
	// Clock and reset
	input  wire logic              I_CLK_SYS,
	input  wire logic              I_RESET,
	// Wishbone slave
	input  wire logic              I_WB_CYC,
	input  wire logic              I_WB_STB,
	input  wire logic              I_WB_WE,
	input  wire logic [3:0]        I_WB_SEL,
	input  wire logic [7:0]        I_WB_ADR,
	input  wire logic [31:0]       I_WB_DAT,
	output logic [31:0]            O_WB_DAT,
	output logic                   O_WB_ACK,
	// Reset sources
	input  wire logic              I_BUTTON_PRESS,
	input  wire logic              I_REMOTE_RESET,
	input  wire logic              I_BACKPLANE_RESET,
	// Logic reload handshake
	input  wire logic              I_LOGIC_DONE,
	// Board status inputs
	input  wire logic              I_HOTSWAP_SAFE,
	input  wire logic              I_SYSTEM_SLOT,
	input  wire logic              I_OVERCURRENT,
	input  wire logic              I_SUPPLIES_GOOD,
	input  wire logic [GA_W-1:0]   I_GEO_ADDR,
	// Timer trigger source
	input  wire logic              I_TIMER_TRIG,
	// Reset outputs
	output logic                   O_LOGIC_RELOAD,
	output logic                   O_CPU_HARD_RESET,
	output logic                   O_LOGIC_RESET,
	output logic                   O_CPU_SOFT_RESET,
	// Indicators
	output logic                   O_LOADED_LED,
	output logic                   O_USER_INDICATOR,
	output logic                   O_HOTSWAP_SAFE_LED,
	output logic                   O_SYSSLOT_LED,
	output logic                   O_OVERCURRENT_LED,
	output logic                   O_SUPPLY_OK_LED,
	// Configuration selects
	output logic                   O_BOOT_SERIAL,
	output logic                   O_SPREAD_CLK_EN,
	output logic [GA_W-1:0]        O_SPREAD_OFFSET,
	output logic                   O_EXT_BUS_CLOCK_MODE,
	output logic                   O_SHORT_SCAN_CHAIN_SEL,
	output logic                   O_CPU_PROBE_SEL,
	output logic                   O_MEZZ_SCAN_BYPASS,
	// Differential back lines
	input  wire logic [1:0]        I_SERIAL_LINE,
	output logic [1:0]             O_SERIAL_LINE,
	output logic [1:0]             O_SERIAL_LINE_OE,
	// Trigger line and its interrupt
	input  wire logic              I_TRIG_LINE,
	output logic                   O_TRIG_LINE,
	output logic                   O_TRIG_LINE_OE,
	output logic                   O_TRIG_IRQ
);

	typedef struct packed {
		brs_pkg::brs_seq_t       seq;
		logic [brs_pkg::CNT_W-1:0] cnt;
		logic [6:0]              setup;
		logic [3:0]              local0;
		logic [7:0]              local6;
		logic [1:0]              trig_ctl;
		logic                    trig_flag;
		logic                    trig_prev;
		logic                    bp_prev;
		logic                    cold_seen;
		logic                    warm_seen;
		logic                    ack;
		logic [31:0]             rdat;
	} brs_top_st_t;

	brs_top_st_t           st_reg;
	brs_top_st_t           st_next;
	brs_pkg::brs_rst_req_t btn_req;
	brs_pkg::brs_rst_req_t rem_req;
	brs_pkg::brs_wb_req_t  wb;
	logic                  wr_en;
	logic                  bp_edge;
	logic                  cold_req;
	logic                  warm_req;
	logic                  trig_rise;

	// Byte-lane merge for writes into a narrow register
	function automatic logic [7:0] lane0(input logic [7:0] old, input brs_pkg::brs_wb_req_t r);
		lane0 = r.sel[0] ? r.dat[7:0] : old;
	endfunction

	// Button and remote timers share one classifier design
	brs_hold_timer #(.HOLD_CYC(HOLD_CYC), .DEB_CYC(DEB_CYC)) u_button (
		.i_clk   (I_CLK_SYS),
		.i_reset (I_RESET),
		.i_press (I_BUTTON_PRESS),
		.o_req   (btn_req)
	);

	brs_hold_timer #(.HOLD_CYC(HOLD_CYC), .DEB_CYC(DEB_CYC)) u_remote (
		.i_clk   (I_CLK_SYS),
		.i_reset (I_RESET),
		.i_press (I_REMOTE_RESET),
		.o_req   (rem_req)
	);

	// Bus request bundle and decode helpers
	assign wb        = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE, sel: I_WB_SEL,
	                     adr: I_WB_ADR, dat: I_WB_DAT};
	assign wr_en     = wb.cyc && wb.stb && wb.we && !st_reg.ack;
	assign bp_edge   = I_BACKPLANE_RESET && !st_reg.bp_prev;
	assign trig_rise = I_TRIG_LINE && !st_reg.trig_prev;

	// Backplane reset kind comes from the setup word
	always_comb begin
		cold_req = btn_req.cold || rem_req.cold; // R1 R3
		warm_req = btn_req.warm || rem_req.warm; // R2 R3
		if (bp_edge) begin
			if (st_reg.setup[brs_pkg::SETUP_BP_RST_COLD]) begin
				cold_req = 1'b1; // R4
			end else begin
				warm_req = 1'b1; // R4
			end
		end
	end

	// Sequencer, registers and bus answer
	always_comb begin
		st_next           = st_reg;
		st_next.bp_prev   = I_BACKPLANE_RESET;
		st_next.trig_prev = I_TRIG_LINE;
		st_next.ack       = wb.cyc && wb.stb && !st_reg.ack;
		st_next.rdat      = '0;

		// Cold beats warm; during a sequence only a cold request in SEQ_WARM has effect, restarting cold
		case (st_reg.seq)
			brs_pkg::SEQ_IDLE: begin
				// Cold request wins when both arrive together
				if (cold_req) begin
					st_next.seq = brs_pkg::SEQ_COLD; // R1
					st_next.cnt = '0;
				end else if (warm_req) begin
					st_next.seq = brs_pkg::SEQ_WARM; // R2
					st_next.cnt = '0;
				end
			end
			brs_pkg::SEQ_COLD: begin
				// Reload pulse, counted from zero
				st_next.cnt = st_reg.cnt + 1'b1;
				if (st_reg.cnt >= brs_pkg::CNT_W'(COLD_CYC - 1)) begin
					st_next.seq = brs_pkg::SEQ_LOAD;
				end
			end
			brs_pkg::SEQ_WARM: begin
				// Short logic reset; a cold request upgrades it
				st_next.cnt = st_reg.cnt + 1'b1;
				if (cold_req) begin
					st_next.seq = brs_pkg::SEQ_COLD;
					st_next.cnt = '0;
				end else if (st_reg.cnt >= brs_pkg::CNT_W'(WARM_CYC - 1)) begin
					st_next.seq = brs_pkg::SEQ_IDLE;
				end
			end
			brs_pkg::SEQ_LOAD: begin
				// Hard reset held until the logic reports it is reloaded
				if (I_LOGIC_DONE) begin
					st_next.seq = brs_pkg::SEQ_IDLE; // R6
				end
			end
			default: st_next.seq = brs_pkg::SEQ_IDLE;
		endcase

		// Status sticky bits, set wins over clear
		if (wr_en && wb.adr == brs_pkg::ADDR_STATUS && wb.sel[0]) begin
			if (wb.dat[brs_pkg::ST_COLD_SEEN]) st_next.cold_seen = 1'b0;
			if (wb.dat[brs_pkg::ST_WARM_SEEN]) st_next.warm_seen = 1'b0;
		end
		if (cold_req) st_next.cold_seen = 1'b1;
		if (warm_req) st_next.warm_seen = 1'b1;

		// Trigger flag, write-one-to-clear, set wins
		if (wr_en && wb.adr == brs_pkg::ADDR_TRIGGER && wb.sel[0]) begin
			st_next.trig_ctl = wb.dat[brs_pkg::TRG_IRQ_EN:brs_pkg::TRG_OUT_EN]; // R12
			if (wb.dat[brs_pkg::TRG_FLAG]) st_next.trig_flag = 1'b0;
		end
		if (!st_reg.trig_ctl[brs_pkg::TRG_OUT_EN] && trig_rise) begin
			st_next.trig_flag = 1'b1; // R12
		end

		// Register writes
		// Casts drop the unimplemented upper bits of the byte lane
		if (wr_en) begin
			if (wb.adr == brs_pkg::ADDR_SETUP) begin
				st_next.setup = 7'(lane0({1'b0, st_reg.setup}, wb));
			end else if (wb.adr == brs_pkg::ADDR_LOCAL0) begin
				st_next.local0 = 4'(lane0({4'h0, st_reg.local0}, wb)); // R11
			end else if (wb.adr == brs_pkg::ADDR_LOCAL6) begin
				st_next.local6 = lane0(st_reg.local6, wb); // R7
			end
		end

		// Register reads; unmapped reads answer zero
		if (wb.cyc && wb.stb && !wb.we && !st_reg.ack) begin
			if (wb.adr == brs_pkg::ADDR_SETUP) begin
				st_next.rdat = {25'h0000000, st_reg.setup};
			end else if (wb.adr == brs_pkg::ADDR_STATUS) begin
				// Loaded bit tracks the sequencer only, not the done input
				st_next.rdat = {29'h00000000, st_reg.warm_seen, st_reg.cold_seen,
				                (st_reg.seq != brs_pkg::SEQ_COLD) &&
				                (st_reg.seq != brs_pkg::SEQ_LOAD)};
			end else if (wb.adr == brs_pkg::ADDR_LOCAL0) begin
				st_next.rdat = {26'h0000000, I_SERIAL_LINE, st_reg.local0}; // R11
			end else if (wb.adr == brs_pkg::ADDR_LOCAL6) begin
				st_next.rdat = {24'h000000, st_reg.local6};
			end else if (wb.adr == brs_pkg::ADDR_TRIGGER) begin
				st_next.rdat = {28'h0000000, I_TRIG_LINE, st_reg.trig_flag, st_reg.trig_ctl};
			end
		end
	end

	// State register
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			st_reg       <= '0;
			st_reg.seq   <= brs_pkg::SEQ_IDLE;
			st_reg.setup <= brs_pkg::SETUP_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Bus outputs
	// Read data is zero outside the ack cycle
	assign O_WB_ACK = st_reg.ack;
	assign O_WB_DAT = st_reg.rdat;

	// Reset outputs driven by the sequencer state
	// Hard reset spans the load wait so the CPU never runs on half-loaded logic
	assign O_LOGIC_RELOAD   = (st_reg.seq == brs_pkg::SEQ_COLD); // R1
	assign O_CPU_HARD_RESET = (st_reg.seq == brs_pkg::SEQ_COLD) ||
	                          (st_reg.seq == brs_pkg::SEQ_LOAD); // R1
	assign O_LOGIC_RESET    = (st_reg.seq == brs_pkg::SEQ_WARM); // R2
	assign O_CPU_SOFT_RESET = (st_reg.seq == brs_pkg::SEQ_WARM); // R2

	// Indicators
	assign O_LOADED_LED       = I_LOGIC_DONE && (st_reg.seq != brs_pkg::SEQ_COLD) &&
	                            (st_reg.seq != brs_pkg::SEQ_LOAD); // R6
	assign O_USER_INDICATOR   = st_reg.local6[brs_pkg::L6_USER_BIT]; // R7
	assign O_HOTSWAP_SAFE_LED = I_HOTSWAP_SAFE; // R8
	assign O_SYSSLOT_LED      = I_SYSTEM_SLOT; // R9
	assign O_OVERCURRENT_LED  = I_OVERCURRENT; // R10
	assign O_SUPPLY_OK_LED    = I_SUPPLIES_GOOD; // R10

	// Configuration selects straight from the setup word; the spread offset is the geographic address, gated by the spread bit
	assign O_BOOT_SERIAL          = st_reg.setup[brs_pkg::SETUP_BOOT_SERIAL]; // R5
	assign O_SPREAD_CLK_EN        = st_reg.setup[brs_pkg::SETUP_SPREAD_CLK]; // R13
	assign O_SPREAD_OFFSET        = st_reg.setup[brs_pkg::SETUP_SPREAD_CLK] ?
	                                I_GEO_ADDR : '0; // R13
	assign O_EXT_BUS_CLOCK_MODE   = st_reg.setup[brs_pkg::SETUP_EXT_CLK_MODE]; // R14
	assign O_SHORT_SCAN_CHAIN_SEL = st_reg.setup[brs_pkg::SETUP_SHORT_CHAIN]; // R15
	assign O_CPU_PROBE_SEL        = st_reg.setup[brs_pkg::SETUP_CPU_PROBE]; // R16
	assign O_MEZZ_SCAN_BYPASS     = st_reg.setup[brs_pkg::SETUP_MEZZ_BYPASS]; // R17

	// Back lines: one data bit each, direction set by software
	assign O_SERIAL_LINE    = st_reg.local0[brs_pkg::L0_OUT_LSB +: 2]; // R11
	assign O_SERIAL_LINE_OE = st_reg.local0[brs_pkg::L0_OE_LSB +: 2]; // R11

	// Trigger: output copies timer pulse, input raises the interrupt
	assign O_TRIG_LINE    = st_reg.trig_ctl[brs_pkg::TRG_OUT_EN] && I_TIMER_TRIG; // R12
	assign O_TRIG_LINE_OE = st_reg.trig_ctl[brs_pkg::TRG_OUT_EN]; // R12
	assign O_TRIG_IRQ     = st_reg.trig_flag && st_reg.trig_ctl[brs_pkg::TRG_IRQ_EN]; // R12

endmodule // brs_top

`default_nettype wire

// *** inc/brs_pkg.sv ***
// Package: constants, register map and types for the board reset and setup block
package brs_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned HOLD_LIMIT_MS   = 2000;
	localparam int unsigned HOLD_LIMIT_CYC  = (CLK_HZ / 1000) * HOLD_LIMIT_MS;
	localparam int unsigned DEBOUNCE_US     = 10000;
	localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000000) * DEBOUNCE_US;
	localparam int unsigned COLD_PULSE_US   = 100;
	localparam int unsigned COLD_PULSE_CYC  = (CLK_HZ / 1000000) * COLD_PULSE_US;
	localparam int unsigned WARM_PULSE_US   = 10;
	localparam int unsigned WARM_PULSE_CYC  = (CLK_HZ / 1000000) * WARM_PULSE_US;
	localparam int unsigned CNT_W           = 32;

	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_SETUP    = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_LOCAL0   = 8'h08;
	localparam logic [7:0] ADDR_LOCAL6   = 8'h0C;
	localparam logic [7:0] ADDR_TRIGGER  = 8'h10;

	// Setup register fields
	localparam int SETUP_SPREAD_CLK   = 0;
	localparam int SETUP_EXT_CLK_MODE = 1;
	localparam int SETUP_MEZZ_BYPASS  = 2;
	localparam int SETUP_SHORT_CHAIN  = 3;
	localparam int SETUP_CPU_PROBE    = 4;
	localparam int SETUP_BOOT_SERIAL  = 5;
	localparam int SETUP_BP_RST_COLD  = 6;
	localparam logic [6:0] SETUP_RESET = 7'h00;

	// Local control 0 fields: [1:0] out data, [3:2] out enable, [5:4] in
	localparam int L0_OUT_LSB = 0;
	localparam int L0_OE_LSB  = 2;
	localparam int L0_IN_LSB  = 4;

	// Local control 6 user indicator bit
	localparam int L6_USER_BIT = 7;

	// Trigger control fields
	localparam int TRG_OUT_EN  = 0;
	localparam int TRG_IRQ_EN  = 1;
	localparam int TRG_FLAG    = 2;
	localparam int TRG_IN_LVL  = 3;

	// Status fields
	localparam int ST_LOADED   = 0;
	localparam int ST_COLD_SEEN = 1;
	localparam int ST_WARM_SEEN = 2;

	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_COLD = 2'b01,
		SEQ_WARM = 2'b10,
		SEQ_LOAD = 2'b11
	} brs_seq_t;

	// Wishbone request carrier
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} brs_wb_req_t;

	// Reset request pulse pair
	typedef struct packed {
		logic cold;
		logic warm;
	} brs_rst_req_t;

endpackage

// *** hw/brs_hold_timer.sv ***
// Debounce and hold-time classifier for one reset input
`timescale 1ns/1ns
`default_nettype none

module brs_hold_timer #(
	parameter int unsigned HOLD_CYC = brs_pkg::HOLD_LIMIT_CYC,
	parameter int unsigned DEB_CYC  = brs_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_reset,
	// Raw active-high press
	input  wire logic              i_press,
	// Classified result, one-cycle pulses
	output brs_pkg::brs_rst_req_t  o_req
);

	typedef struct packed {
		logic                        sync1;
		logic                        sync2;
		logic                        clean;
		logic [brs_pkg::CNT_W-1:0]   deb_cnt;
		logic [brs_pkg::CNT_W-1:0]   hold_cnt;
		brs_pkg::brs_rst_req_t       req;
	} brs_ht_st_t;

	brs_ht_st_t st_reg;
	brs_ht_st_t st_next;

	// Synchronise, debounce, then measure; kind decided on release (R18)
	always_comb begin
		st_next       = st_reg;
		st_next.sync1 = i_press;
		st_next.sync2 = st_reg.sync1;
		st_next.req   = '0;
		if (st_reg.sync2 == st_reg.clean) begin
			st_next.deb_cnt = '0;
		end else if (st_reg.deb_cnt >= brs_pkg::CNT_W'(DEB_CYC - 1)) begin
			st_next.deb_cnt = '0;
			st_next.clean   = st_reg.sync2; // R18
		end else begin
			st_next.deb_cnt = st_reg.deb_cnt + 1'b1;
		end
		if (st_reg.clean) begin
			// Saturate so a very long hold never wraps back to warm
			if (st_reg.hold_cnt <= brs_pkg::CNT_W'(HOLD_CYC)) begin
				st_next.hold_cnt = st_reg.hold_cnt + 1'b1;
			end
		end else begin
			st_next.hold_cnt = '0;
		end
		if (st_reg.clean && !st_next.clean) begin
			if (st_reg.hold_cnt > brs_pkg::CNT_W'(HOLD_CYC)) begin
				st_next.req.cold = 1'b1; // R1 R3
			end else begin
				st_next.req.warm = 1'b1; // R2 R3
			end
		end
	end

	// State register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_req = st_reg.req;

endmodule // brs_hold_timer

`default_nettype wire

// *** bench/brs_partner.sv ***
// Model of the reset sources and the logic reload agent
`timescale 1ns/1ns
`default_nettype none

module brs_partner (
	// Clock and board state
	input  wire logic i_clk,
	input  wire logic i_reload,
	input  wire logic i_hard,
	// Levels driven toward the board
	output logic      o_button,
	output logic      o_remote,
	output logic      o_backplane,
	output logic      o_done
);
	logic [3:0] load_cnt;

	// Logic starts configured after power-on
	initial begin
		o_button = 1'b0;
		o_remote = 1'b0;
		o_backplane = 1'b0;
		o_done = 1'b1;
		load_cnt = 4'h0;
	end

	// Hold one source for n cycles: 0 button, 1 remote, 2 backplane
	task automatic hold(input int src, input int n);
		@(posedge i_clk);
		if (src == 0) o_button <= 1'b1;
		else if (src == 1) o_remote <= 1'b1;
		else o_backplane <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_button <= 1'b0;
		o_remote <= 1'b0;
		o_backplane <= 1'b0;
	endtask

	// Reload takes a few cycles, so the loaded flag has a dark spell
	always @(posedge i_clk) begin
		if (i_reload) begin
			o_done <= 1'b0;
			load_cnt <= 4'h0;
		end else if (i_hard && !o_done) begin
			load_cnt <= load_cnt + 4'h1;
			if (load_cnt == 4'h3) o_done <= 1'b1;
		end
	end
endmodule // brs_partner
`default_nettype wire

// *** bench/brs_top_assertions.sv ***
// Concurrent checks on the ports of the reset and setup block
`timescale 1ns/1ns
`default_nettype none

module brs_top_assertions #(
	parameter int COLD_CYC = 10,
	parameter int WARM_CYC = 5
) (
	input wire logic       I_CLK_SYS,
	input wire logic       I_RESET,
	input wire logic       I_WB_CYC,
	input wire logic       I_WB_STB,
	input wire logic       O_WB_ACK,
	input wire logic       I_HOTSWAP_SAFE,
	input wire logic       O_HOTSWAP_SAFE_LED,
	input wire logic       I_SYSTEM_SLOT,
	input wire logic       O_SYSSLOT_LED,
	input wire logic       I_OVERCURRENT,
	input wire logic       O_OVERCURRENT_LED,
	input wire logic       I_SUPPLIES_GOOD,
	input wire logic       O_SUPPLY_OK_LED,
	input wire logic       O_LOGIC_RELOAD,
	input wire logic       O_CPU_HARD_RESET,
	input wire logic       O_LOGIC_RESET,
	input wire logic       O_CPU_SOFT_RESET,
	input wire logic       O_LOADED_LED,
	input wire logic       O_SPREAD_CLK_EN,
	input wire logic [4:0] O_SPREAD_OFFSET,
	input wire logic [4:0] I_GEO_ADDR,
	input wire logic       I_TIMER_TRIG,
	input wire logic       O_TRIG_LINE,
	input wire logic       O_TRIG_LINE_OE,
	input wire logic       O_TRIG_IRQ
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);

	// Bus answers one cycle after a fresh request, never twice in a row
	a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
		else $error("ack missing after request");
	a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack held two cycles");
	// Indicators follow their sources directly
	a_hotswap_led: assert property (O_HOTSWAP_SAFE_LED == I_HOTSWAP_SAFE)
		else $error("hot-swap indicator wrong");
	a_sysslot_led: assert property (O_SYSSLOT_LED == I_SYSTEM_SLOT)
		else $error("system slot indicator wrong");
	a_power_leds: assert property ({O_OVERCURRENT_LED, O_SUPPLY_OK_LED} == {I_OVERCURRENT, I_SUPPLIES_GOOD})
		else $error("power indicators wrong");
	// Reload keeps the loaded flag dark and the CPU in hard reset
	a_reload_dark: assert property (O_LOGIC_RELOAD |-> !O_LOADED_LED && O_CPU_HARD_RESET)
		else $error("loaded indicator lit during reload");
	a_cold_length: assert property ($rose(O_LOGIC_RELOAD) |-> ##COLD_CYC (!O_LOGIC_RELOAD && O_CPU_HARD_RESET))
		else $error("cold phase length wrong");
	// Warm reset pairs logic reset with the soft exception, no hard reset
	a_warm_pair: assert property (O_CPU_SOFT_RESET |-> O_LOGIC_RESET && !O_CPU_HARD_RESET)
		else $error("warm reset outputs inconsistent");
	a_warm_length: assert property ($rose(O_CPU_SOFT_RESET) |-> ##WARM_CYC !O_CPU_SOFT_RESET)
		else $error("warm pulse too long");
	a_spread_offset: assert property (O_SPREAD_CLK_EN && $stable(I_GEO_ADDR) |-> O_SPREAD_OFFSET == I_GEO_ADDR)
		else $error("spread offset not geographic address");
	a_trig_gate: assert property (O_TRIG_LINE == (O_TRIG_LINE_OE && I_TIMER_TRIG))
		else $error("trigger output not gated timer pulse");

	// Main scenarios reached
	c_cold: cover property ($rose(O_LOGIC_RELOAD));
	c_warm: cover property ($rose(O_CPU_SOFT_RESET));
	c_irq: cover property ($rose(O_TRIG_IRQ));
endmodule // brs_top_assertions

bind brs_top brs_top_assertions #(.COLD_CYC(COLD_CYC), .WARM_CYC(WARM_CYC)) u_chk (
	.I_CLK_SYS, .I_RESET, .I_WB_CYC, .I_WB_STB, .O_WB_ACK, .I_HOTSWAP_SAFE,
	.O_HOTSWAP_SAFE_LED, .I_SYSTEM_SLOT, .O_SYSSLOT_LED, .I_OVERCURRENT, .O_OVERCURRENT_LED,
	.I_SUPPLIES_GOOD, .O_SUPPLY_OK_LED, .O_LOGIC_RELOAD, .O_CPU_HARD_RESET, .O_LOGIC_RESET,
	.O_CPU_SOFT_RESET, .O_LOADED_LED, .O_SPREAD_CLK_EN, .O_SPREAD_OFFSET, .I_GEO_ADDR,
	.I_TIMER_TRIG, .O_TRIG_LINE, .O_TRIG_LINE_OE, .O_TRIG_IRQ);
`default_nettype wire

// *** bench/brs_top_test.sv ***
// Self-checking bench for the board reset and setup block
`timescale 1ns/1ns
`default_nettype none

module brs_top_test;
	logic        I_CLK_SYS, I_RESET, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK;
	logic [3:0]  I_WB_SEL;
	logic [7:0]  I_WB_ADR;
	logic [31:0] I_WB_DAT, O_WB_DAT, q;
	logic        I_BUTTON_PRESS, I_REMOTE_RESET, I_BACKPLANE_RESET, I_LOGIC_DONE;
	logic        I_HOTSWAP_SAFE, I_SYSTEM_SLOT, I_OVERCURRENT, I_SUPPLIES_GOOD, I_TIMER_TRIG;
	logic [4:0]  I_GEO_ADDR, O_SPREAD_OFFSET;
	logic        O_LOGIC_RELOAD, O_CPU_HARD_RESET, O_LOGIC_RESET, O_CPU_SOFT_RESET;
	logic        O_LOADED_LED, O_USER_INDICATOR, O_HOTSWAP_SAFE_LED, O_SYSSLOT_LED;
	logic        O_OVERCURRENT_LED, O_SUPPLY_OK_LED, O_BOOT_SERIAL, O_SPREAD_CLK_EN;
	logic        O_EXT_BUS_CLOCK_MODE, O_SHORT_SCAN_CHAIN_SEL, O_CPU_PROBE_SEL, O_MEZZ_SCAN_BYPASS;
	logic [1:0]  I_SERIAL_LINE, O_SERIAL_LINE, O_SERIAL_LINE_OE, far_sl;
	logic        I_TRIG_LINE, O_TRIG_LINE, O_TRIG_LINE_OE, O_TRIG_IRQ, far_tl;
	int          bad_count, comparisons, i;

	// Shortened counts keep the run brief
	brs_top #(.HOLD_CYC(200), .DEB_CYC(4), .COLD_CYC(10), .WARM_CYC(5)) dut (.*);
	brs_partner p (.i_clk(I_CLK_SYS), .i_reload(O_LOGIC_RELOAD), .i_hard(O_CPU_HARD_RESET),
		.o_button(I_BUTTON_PRESS), .o_remote(I_REMOTE_RESET),
		.o_backplane(I_BACKPLANE_RESET), .o_done(I_LOGIC_DONE));

	// Wire levels follow the board's enables; the far end drives whenever the board does not
	assign I_SERIAL_LINE = (O_SERIAL_LINE_OE & O_SERIAL_LINE) | (~O_SERIAL_LINE_OE & far_sl);
	assign I_TRIG_LINE = O_TRIG_LINE_OE ? O_TRIG_LINE : far_tl;

	always #20 I_CLK_SYS = ~I_CLK_SYS;

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One classic bus cycle; read data lands in q at the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge I_CLK_SYS);
		I_WB_CYC <= 1'b1;
		I_WB_STB <= 1'b1;
		I_WB_WE <= w;
		I_WB_ADR <= a;
		I_WB_DAT <= d;
		do begin
			@(posedge I_CLK_SYS);
			n++;
		end while (O_WB_ACK !== 1'b1 && n < 20);
		q = O_WB_DAT;
		I_WB_CYC <= 1'b0;
		I_WB_STB <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			$display("[FAIL] bus ack expected 1 seen timeout");
			tally_and_finish();
		end
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return O_LOGIC_RELOAD;
			1: return O_CPU_SOFT_RESET;
			default: return O_CPU_HARD_RESET;
		endcase
	endfunction

	task automatic wait_on(input int s, input logic v);
		int n;
		for (n = 0; n < 400 && sig(s) !== v; n++) @(posedge I_CLK_SYS);
		if (n >= 400) begin
			bad_count++;
			$display("[FAIL] wait %0d expected %b seen timeout", s, v);
			tally_and_finish();
		end
	endtask

	// Hold a source, then check the kind of reset and the return to idle
	task automatic rst_case(input int src, input int n, input logic cold);
		p.hold(src, n);
		wait_on(cold ? 0 : 1, 1'b1);
		chk("hard reset", cold, O_CPU_HARD_RESET);
		chk("logic reset", !cold, O_LOGIC_RESET);
		chk("loaded led", !cold, O_LOADED_LED);
		wait_on(2, 1'b0);
		wait_on(1, 1'b0);
		@(posedge I_CLK_SYS);
		chk("loaded led idle", 1, O_LOADED_LED);
		$display("test reset source %0d cold %b done", src, cold);
	endtask

	initial begin
		repeat (100000) @(posedge I_CLK_SYS);
		bad_count++;
		$display("[FAIL] run expected end seen timeout");
		tally_and_finish();
	end

	initial begin
		{I_CLK_SYS, I_WB_CYC, I_WB_STB, I_WB_WE, I_TIMER_TRIG, far_tl} = 6'h00;
		{I_HOTSWAP_SAFE, I_SYSTEM_SLOT, I_OVERCURRENT, I_SUPPLIES_GOOD} = 4'h0;
		{I_WB_ADR, I_WB_DAT, I_WB_SEL} = 44'h00000000F;
		I_RESET = 1'b1;
		I_GEO_ADDR = 5'h15;
		far_sl = 2'b01;
		repeat (20) @(posedge I_CLK_SYS);
		I_RESET <= 1'b0;
		wb(0, 8'h00, 0);
		chk("setup reset", 0, q);
		// Setup bits 0 to 5 each reach only their select line
		for (i = 0; i < 6; i++) begin
			wb(1, 8'h00, 32'h1 << i);
			chk("selects", 32'h1 << i, {26'h0, O_BOOT_SERIAL, O_CPU_PROBE_SEL,
				O_SHORT_SCAN_CHAIN_SEL, O_MEZZ_SCAN_BYPASS, O_EXT_BUS_CLOCK_MODE, O_SPREAD_CLK_EN});
			chk("offset", i == 0 ? 5'h15 : 5'h00, O_SPREAD_OFFSET);
		end
		$display("test setup selects done");
		wb(1, 8'h0C, 32'h80);
		chk("user on", 1, O_USER_INDICATOR);
		wb(1, 8'h0C, 32'h7F);
		chk("user off", 0, O_USER_INDICATOR);
		// Back lines driven, then released to the far end
		wb(1, 8'h08, 32'h0E);
		repeat (3) @(posedge I_CLK_SYS);
		wb(0, 8'h08, 0);
		chk("lines driven", 32'h2E, q);
		wb(1, 8'h08, 32'h01);
		repeat (3) @(posedge I_CLK_SYS);
		wb(0, 8'h08, 0);
		chk("lines released", 32'h11, q);
		$display("test back lines done");
		wb(1, 8'h10, 32'h1);
		I_TIMER_TRIG <= 1'b1;
		@(posedge I_CLK_SYS);
		@(posedge I_CLK_SYS);
		chk("trigger out", 3, {O_TRIG_LINE_OE, O_TRIG_LINE});
		I_TIMER_TRIG <= 1'b0;
		wb(1, 8'h10, 32'h2);
		far_tl <= 1'b1;
		repeat (4) @(posedge I_CLK_SYS);
		chk("trigger irq", 1, O_TRIG_IRQ);
		wb(0, 8'h10, 0);
		chk("trigger reg", 32'hE, q);
		wb(1, 8'h10, 32'h6);
		chk("irq cleared", 0, O_TRIG_IRQ);
		far_tl <= 1'b0;
		wb(1, 8'h20, 32'hFF);
		wb(0, 8'h20, 0);
		chk("unmapped", 0, q);
		$display("test trigger and unmapped done");
		for (i = 0; i < 16; i++) begin
			{I_HOTSWAP_SAFE, I_SYSTEM_SLOT, I_OVERCURRENT, I_SUPPLIES_GOOD} <= i[3:0];
			@(posedge I_CLK_SYS);
			@(posedge I_CLK_SYS);
			chk("leds", i, {O_HOTSWAP_SAFE_LED, O_SYSSLOT_LED,
				O_OVERCURRENT_LED, O_SUPPLY_OK_LED});
		end
		$display("test indicators done");
		rst_case(0, 50, 1'b0);
		rst_case(0, 300, 1'b1);
		rst_case(1, 50, 1'b0);
		rst_case(1, 300, 1'b1);
		wb(1, 8'h00, 32'h00);
		rst_case(2, 3, 1'b0);
		wb(1, 8'h00, 32'h40);
		rst_case(2, 3, 1'b1);
		// Status: loaded plus both sticky kinds, then write-one-to-clear
		wb(0, 8'h04, 0);
		chk("status", 32'h7, q);
		wb(1, 8'h04, 32'h6);
		wb(0, 8'h04, 0);
		chk("status cleared", 32'h1, q);
		$display("test status done");
		tally_and_finish();
	end
endmodule // brs_top_test
`default_nettype wire
